// File: design/ccd_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - rising fault-reset bit power-cycles the curtain; link side keeps running
// - restart issued only on rising edge of restart bit; levels do nothing
// - one of four configurations 0..3 active, exactly one at a time
// - values above 3 select configuration from the two low bits
// - configuration in effect is reported back to the controller
// - configuration 0 is the default until another is commanded
// - after valid restart, safety status goes high if field clear and run mode is on
// - restart-needed is 1 while a restart is needed to turn on
// - link fault flag 0 while link operates, 1 when faulted
// - safety status 0 in safe state, 1 when outputs on
module ccd_decoder
   import ccd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic field_clear_pin,
   input wire logic link_ok_pin,
   input wire logic run_mode_pin,
   output logic curtain_power_off,
   output logic curtain_restart,
   output logic safety_out,
   output logic [1:0] config_select,
   output logic irq
);
   // ****************************************
   // synchronised curtain pins
   // ****************************************
   logic field_clear;
   logic link_ok;
   logic run_mode;

   ccd_sync3 u_sync_field (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(field_clear_pin),
      .sync_out(field_clear)
   );
   ccd_sync3 u_sync_link (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(link_ok_pin),
      .sync_out(link_ok)
   );
   ccd_sync3 u_sync_run (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(run_mode_pin),
      .sync_out(run_mode)
   );

   // ****************************************
   // command capture over apb
   // ****************************************
   ccd_cmd_t cmd;
   ccd_cmd_t next_cmd;
   logic cmd_update;
   logic next_cmd_update;
   logic wr_access;
   logic rd_access;
   logic addr_ok;

   assign wr_access = psel & penable & pwrite;
   assign rd_access = psel & penable & ~pwrite;
   assign addr_ok = (paddr == CCD_CMD_OFF) || (paddr == CCD_STAT_OFF) || (paddr == CCD_IRQ_STAT_OFF) ||
                    (paddr == CCD_IRQ_MASK_OFF) || (paddr == CCD_CURT_OFF);

   // a write to the command word is one cyclic update
   always_comb begin
      next_cmd = cmd;
      next_cmd_update = 1'b0;
      if (wr_access && paddr == CCD_CMD_OFF) begin
         next_cmd.config_cmd = pwdata[CCD_CMD_CFG_LSB +: 8];
         next_cmd.restart = pwdata[CCD_CMD_RST_BIT];
         next_cmd.fault_reset = pwdata[CCD_CMD_FRST_BIT];
         next_cmd_update = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cmd <= '0;
         cmd_update <= 1'b0;
      end else begin
         cmd <= next_cmd;
         cmd_update <= next_cmd_update;
      end
   end

   // ****************************************
   // edge detection per update
   // ****************************************
   logic restart_rise;
   logic frst_rise;

   ccd_edge u_edge_restart (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .update(cmd_update),
      .level(cmd.restart),
      .rise(restart_rise)
   );
   ccd_edge u_edge_frst (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .update(cmd_update),
      .level(cmd.fault_reset),
      .rise(frst_rise)
   );

   // ****************************************
   // curtain control state
   // ****************************************
   typedef enum logic [3:0] {
      CCD_ST_OFF = 4'h1,
      CCD_ST_WAIT = 4'h2,
      CCD_ST_ON = 4'h4,
      CCD_ST_PWR = 4'h8
   } ccd_state_t;

   ccd_state_t state;
   ccd_state_t next_state;
   logic [7:0] frst_cnt;
   logic [7:0] next_frst_cnt;
   logic [1:0] next_config;
   logic next_restart_out;
   logic next_safety;
   logic next_power_off;
   logic cfg_change;

   assign cfg_change = cmd_update && (ccd_cfg_of(cmd.config_cmd) != config_select);

   always_comb begin
      next_state = state;
      next_frst_cnt = frst_cnt;
      next_restart_out = 1'b0;
      next_config = cfg_change ? ccd_cfg_of(cmd.config_cmd) : config_select;
      unique case (state)
         CCD_ST_OFF: begin
            if (restart_rise) begin
               next_restart_out = 1'b1;
               next_state = CCD_ST_WAIT;
            end
         end
         CCD_ST_WAIT: begin
            next_state = (field_clear && run_mode) ? CCD_ST_ON : CCD_ST_OFF;
         end
         CCD_ST_ON: begin
            if (!field_clear || !run_mode || cfg_change) begin
               next_state = CCD_ST_OFF;
            end
         end
         CCD_ST_PWR: begin
            if (frst_cnt == 8'h00) begin
               next_state = CCD_ST_OFF;
            end else begin
               next_frst_cnt = frst_cnt - 8'h01;
            end
         end
         default: next_state = CCD_ST_OFF;
      endcase
      // fault reset beats all; apb side untouched
      if (frst_rise) begin
         next_state = CCD_ST_PWR;
         next_frst_cnt = 8'(CCD_FRST_CYC - 1);
         next_restart_out = 1'b0;
      end
      next_safety = (next_state == CCD_ST_ON);
      next_power_off = (next_state == CCD_ST_PWR);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= CCD_ST_OFF;
         frst_cnt <= 8'h00;
         config_select <= CCD_CFG_DEFAULT;
         curtain_restart <= 1'b0;
         safety_out <= 1'b0;
         curtain_power_off <= 1'b0;
      end else begin
         state <= next_state;
         frst_cnt <= next_frst_cnt;
         config_select <= next_config;
         curtain_restart <= next_restart_out;
         safety_out <= next_safety;
         curtain_power_off <= next_power_off;
      end
   end

   // ****************************************
   // status word and interrupts
   // ****************************************
   ccd_stat_t stat;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic [3:0] next_irq_stat;
   logic [3:0] next_irq_mask;
   logic [3:0] events;
   logic link_fault_prev;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;

   always_comb begin
      stat.operating_run_flag = run_mode;
      stat.link_fault_flag = ~link_ok;
      stat.restart_needed_flag = (state == CCD_ST_OFF);
      stat.safety_status = safety_out;
      stat.config_select = config_select;
   end

   always_comb begin
      events = '0;
      events[CCD_IRQ_FRST] = frst_rise;
      events[CCD_IRQ_RST] = restart_rise;
      events[CCD_IRQ_CFG] = cfg_change;
      events[CCD_IRQ_LINK] = stat.link_fault_flag & ~link_fault_prev;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      // write one clears; a same-cycle event wins
      if (wr_access && paddr == CCD_IRQ_STAT_OFF) begin
         next_irq_stat = irq_stat & ~pwdata[3:0];
      end
      next_irq_stat = next_irq_stat | events;
      if (wr_access && paddr == CCD_IRQ_MASK_OFF) begin
         next_irq_mask = pwdata[3:0];
      end
      next_irq = |(next_irq_stat & next_irq_mask);
      // zero-wait slave: answer lands in the access cycle
      next_pready = psel & ~penable;
      next_pslverr = psel & ~penable & ~addr_ok;
      next_prdata = 32'h0;
      if (psel && !penable) begin
         unique case (paddr)
            CCD_CMD_OFF: next_prdata = {22'h0, cmd.fault_reset, cmd.restart, cmd.config_cmd};
            CCD_STAT_OFF: next_prdata = {26'h0, stat};
            CCD_IRQ_STAT_OFF: next_prdata = {28'h0, irq_stat};
            CCD_IRQ_MASK_OFF: next_prdata = {28'h0, irq_mask};
            CCD_CURT_OFF: next_prdata = {29'h0, curtain_power_off, curtain_restart, field_clear};
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irq_stat <= 4'h0;
         irq_mask <= CCD_MASK_RESET;
         // synchronisers clear to 0, so the flag reads 1 after reset; start high to avoid a false event
         link_fault_prev <= 1'b1;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         link_fault_prev <= stat.link_fault_flag;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // restart pulse
   restart_one_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      curtain_restart |=> !curtain_restart)
      else $error("restart pulse longer than one cycle");
   restart_cause_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(curtain_restart) |-> $past(restart_rise))
      else $error("restart without command rise");
   frst_power_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frst_rise |=> curtain_power_off [*8])
      else $error("fault reset did not hold power off");
   cfg_lowbits_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cmd_update |=> config_select == $past(cmd.config_cmd[1:0]))
      else $error("configuration not from low bits");
   cfg_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !cmd_update |=> $stable(config_select))
      else $error("configuration changed without command");
   status_on_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (curtain_restart && field_clear && run_mode && !frst_rise)
      |=> safety_out)
      else $error("safety status not raised after restart");
   status_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !field_clear |=> !safety_out)
      else $error("safety status high with field blocked");
   need_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      stat.restart_needed_flag |-> !safety_out)
      else $error("restart needed while outputs on");
   link_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      stat.link_fault_flag == !link_ok)
      else $error("link fault flag wrong");
endmodule

// File: design/ccd_pkg.sv
package ccd_pkg;
   // cyclic command word from the controller
   typedef struct packed {
      logic       fault_reset;
      logic       restart;
      logic [7:0] config_cmd;
   } ccd_cmd_t;

   // curtain status fields reported back
   typedef struct packed {
      logic       operating_run_flag;
      logic       link_fault_flag;
      logic       restart_needed_flag;
      logic       safety_status;
      logic [1:0] config_select;
   } ccd_stat_t;

   // register byte offsets
   localparam logic [11:0] CCD_CMD_OFF = 12'h000;
   localparam logic [11:0] CCD_STAT_OFF = 12'h004;
   localparam logic [11:0] CCD_IRQ_STAT_OFF = 12'h008;
   localparam logic [11:0] CCD_IRQ_MASK_OFF = 12'h00C;
   localparam logic [11:0] CCD_CURT_OFF = 12'h010;

   // command register field positions
   localparam int CCD_CMD_CFG_LSB = 0;
   localparam int CCD_CMD_RST_BIT = 8;
   localparam int CCD_CMD_FRST_BIT = 9;
   localparam int CCD_CMD_UPD_BIT = 10;

   // interrupt status bit positions
   localparam int CCD_IRQ_FRST = 0;
   localparam int CCD_IRQ_RST = 1;
   localparam int CCD_IRQ_CFG = 2;
   localparam int CCD_IRQ_LINK = 3;

   // reset values
   localparam logic [1:0] CCD_CFG_DEFAULT = 2'h0;
   localparam logic [3:0] CCD_MASK_RESET = 4'h0;

   // fault-reset pulse length: 1 us at 250 MHz
   localparam int CCD_CLK_MHZ = 250;
   localparam int CCD_FRST_NS = 1000;
   localparam int CCD_FRST_CYC = (CCD_FRST_NS * CCD_CLK_MHZ) / 1000;

   // low two bits pick the configuration, upper bits ignored
   function automatic logic [1:0] ccd_cfg_of(input logic [7:0] cmd);
      return cmd[1:0];
   endfunction
endpackage

// File: design/ccd_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes when stages two and three agree
module ccd_sync3
   import ccd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_out;

   // ****************************************
   // shift and agree
   // ****************************************
   always_comb begin
      next_stage = {stage[1:0], async_in};
      next_out = (stage[2] == stage[1]) ? stage[2] : sync_out;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         stage <= 3'h0;
         sync_out <= 1'b0;
      end else begin
         stage <= next_stage;
         sync_out <= next_out;
      end
   end
endmodule

// File: design/ccd_edge.sv
`timescale 1ns/1ps
// rising-edge detector sampled only on command updates
module ccd_edge
   import ccd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic update,
   input wire logic level,
   output logic rise
);
   logic prev;
   logic next_prev;
   logic next_rise;

   // compare new value against the previous update's value
   always_comb begin
      next_prev = update ? level : prev;
      next_rise = update & level & ~prev;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         prev <= 1'b0;
         rise <= 1'b0;
      end else begin
         prev <= next_prev;
         rise <= next_rise;
      end
   end
endmodule

// File: testbench/ccd_curtain_model.sv
`timescale 1ns/1ps
// ****************
// curtain side model
// ****************
module ccd_curtain_model (
   input wire logic sys_clk,
   input wire logic curtain_power_off,
   input wire logic field_blocked,
   input wire logic link_drop,
   output logic field_clear_pin,
   output logic link_ok_pin,
   output logic run_mode_pin
);
   logic [3:0] boot_cnt = 4'h0;
   // reboot delay so run mode lags the power-off release
   always_ff @(posedge sys_clk) begin
      if (curtain_power_off) begin
         boot_cnt <= 4'hA;
      end else if (boot_cnt != 4'h0) begin
         boot_cnt <= boot_cnt - 4'h1;
      end
   end
   // pin levels seen by the block
   assign run_mode_pin = !curtain_power_off && (boot_cnt == 4'h0);
   assign field_clear_pin = !field_blocked;
   assign link_ok_pin = !link_drop;
endmodule

// File: testbench/curtain_command_decoder_tb_top.sv
`timescale 1ns/1ps
module curtain_command_decoder_tb_top
   import ccd_pkg::*;
;
   // ****************
   // signals and instances
   // ****************
   localparam int HOLD_PRESET = 10; // shortened operator hold preset
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, curtain_power_off, curtain_restart, safety_out, irq;
   logic field_clear_pin, link_ok_pin, run_mode_pin;
   logic [1:0] config_select;
   logic field_blocked = 1'b0;
   logic link_drop = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int total_checks = 0;
   int rst_pulses = 0;
   int off_cycles = 0;

   always #2 sys_clk = ~sys_clk;

   ccd_decoder u_ccd_decoder (
      .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .field_clear_pin(field_clear_pin),
      .link_ok_pin(link_ok_pin), .run_mode_pin(run_mode_pin),
      .curtain_power_off(curtain_power_off), .curtain_restart(curtain_restart),
      .safety_out(safety_out), .config_select(config_select), .irq(irq)
   );

   ccd_curtain_model u_ccd_curtain_model (
      .sys_clk(sys_clk), .curtain_power_off(curtain_power_off),
      .field_blocked(field_blocked), .link_drop(link_drop),
      .field_clear_pin(field_clear_pin), .link_ok_pin(link_ok_pin),
      .run_mode_pin(run_mode_pin)
   );

   // curtain-side event counters
   always @(posedge sys_clk) begin
      if (curtain_restart === 1'b1) rst_pulses++;
      if (curtain_power_off === 1'b1) off_cycles++;
   end

   // ****************
   // shared tasks
   // ****************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a stuck transfer
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // one cyclic command update
   task automatic cmd(input logic rst, input logic frst);
      apb(1'b1, CCD_CMD_OFF, {22'h0, frst, rst, cfg});
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hold must beat the preset; one-shot on release
   task automatic op_restart(input int hold);
      repeat (hold) @(posedge sys_clk);
      if (hold > HOLD_PRESET) begin
         cmd(1'b1, 1'b0);
         cmd(1'b0, 1'b0);
      end
      settle(12);
   endtask

   task automatic t_reset();
      settle(8);
      chk("config_select", 32'h0, {30'h0, config_select});
      chk("safety_out", 32'h0, {31'h0, safety_out});
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("status", 32'h28, rd);
      apb(1'b0, CCD_IRQ_MASK_OFF, 32'h0);
      chk("irq_mask", {28'h0, CCD_MASK_RESET}, rd);
      $display("test reset done");
   endtask

   // low two bits pick the configuration
   task automatic t_config();
      logic [7:0] vals [4] = '{8'h02, 8'h01, 8'hFE, 8'h03};
      foreach (vals[i]) begin
         cfg = vals[i];
         cmd(1'b0, 1'b0);
         settle(4);
         chk("config_select", {30'h0, cfg[1:0]}, {30'h0, config_select});
         apb(1'b0, CCD_STAT_OFF, 32'h0);
         chk("readback", {30'h0, cfg[1:0]}, {30'h0, rd[1:0]});
      end
      apb(1'b1, CCD_IRQ_STAT_OFF, 32'hF);
      cfg = 8'h13; // same as active one, no change expected
      cmd(1'b0, 1'b0);
      settle(4);
      apb(1'b0, CCD_IRQ_STAT_OFF, 32'h0);
      chk("cfg event", 32'h0, {31'h0, rd[CCD_IRQ_CFG]});
      cfg = 8'h04;
      cmd(1'b0, 1'b0);
      settle(4);
      chk("config_select", 32'h0, {30'h0, config_select});
      apb(1'b0, CCD_IRQ_STAT_OFF, 32'h0);
      chk("cfg event", 32'h1, {31'h0, rd[CCD_IRQ_CFG]});
      $display("test config done");
   endtask

   task automatic t_restart();
      rst_pulses = 0;
      op_restart(3);
      chk("restart pulses", 32'h0, rst_pulses);
      op_restart(HOLD_PRESET + 2);
      chk("restart pulses", 32'h1, rst_pulses);
      chk("safety_out", 32'h1, {31'h0, safety_out});
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("status", 32'h24, rd);
      chk("curtain_ready_qual", 32'h1, {31'h0, rd[5] & ~rd[4] & rd[2]});
      $display("test restart done");
   endtask

   // fault reset power-cycles the curtain, bus keeps answering
   task automatic t_fault();
      off_cycles = 0;
      cmd(1'b0, 1'b1);
      // outputs drop two cycles after the write edge
      settle(2);
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("safety bit", 32'h0, {31'h0, rd[2]});
      settle(1);
      chk("power_off", 32'h1, {31'h0, curtain_power_off});
      settle(300);
      chk("off cycles", CCD_FRST_CYC, off_cycles);
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("status", 32'h28, rd);
      chk("operator restart lamp", 32'h1, {31'h0, rd[3]});
      cmd(1'b0, 1'b1);
      settle(8);
      chk("off cycles", CCD_FRST_CYC, off_cycles);
      cmd(1'b0, 1'b0);
      @(posedge sys_clk);
      field_blocked <= 1'b1;
      cmd(1'b1, 1'b0);
      settle(12);
      chk("safety_out", 32'h0, {31'h0, safety_out});
      rst_pulses = 0;
      field_blocked <= 1'b0;
      cmd(1'b1, 1'b0);
      settle(12);
      chk("restart pulses", 32'h0, rst_pulses);
      cmd(1'b0, 1'b0);
      cmd(1'b1, 1'b0);
      settle(12);
      chk("safety_out", 32'h1, {31'h0, safety_out});
      $display("test fault done");
   endtask

   // link fault flag, masked interrupt, unmapped place
   task automatic t_irq();
      apb(1'b1, CCD_IRQ_STAT_OFF, 32'hF);
      @(posedge sys_clk);
      link_drop <= 1'b1;
      settle(10);
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("link fault", 32'h1, {31'h0, rd[4]});
      chk("curtain_ready_qual", 32'h0, {31'h0, rd[5] & ~rd[4]});
      apb(1'b0, CCD_IRQ_STAT_OFF, 32'h0);
      chk("link event", 32'h1, {31'h0, rd[CCD_IRQ_LINK]});
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, CCD_IRQ_MASK_OFF, 32'h8);
      settle(2);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, CCD_IRQ_STAT_OFF, 32'h8);
      settle(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      link_drop <= 1'b0;
      settle(10);
      apb(1'b0, CCD_STAT_OFF, 32'h0);
      chk("link fault", 32'h0, {31'h0, rd[4]});
      apb(1'b0, 12'h020, 32'h0);
      chk("pslverr", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      // brief link drop of three cycles must still leave a latched event
      @(posedge sys_clk);
      link_drop <= 1'b1;
      repeat (3) @(posedge sys_clk);
      link_drop <= 1'b0;
      settle(8);
      apb(1'b0, CCD_IRQ_STAT_OFF, 32'h0);
      chk("link pulse event", 32'h1, {31'h0, rd[CCD_IRQ_LINK]});
      $display("test irq done");
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_config();
      t_restart();
      t_fault();
      t_irq();
      end_of_test();
   end

   // watchdog well past the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      end_of_test();
   end
endmodule
